// file: common/ccdts_pkg.sv
// Package for the CCD readout timing sequencer: timing figures, cycle counts, geometry, modes.
// Assumes a single 20 MHz system clock.
`default_nettype none
package ccdts_pkg;
	localparam int CLK_MHZ = 20;
	localparam int CLK_PERIOD_NS = 50;
	// Minimum intervals in their own units, as printed
	localparam int HORIZ_DELAY_NS = 200;
	localparam int VERT_STEP_NS = 200;
	localparam int PD_XFER_NS = 300;
	localparam int PEDESTAL_US = 15;
	localparam int VERT_DELAY_US = 5;
	localparam int FRAME_DELAY_US = 15;
	localparam int LINE_END_NS = 25;
	localparam int HORIZ_PERIOD_NS = 25;
	localparam int RESET_PULSE_PS = 2500; // Held in ps, the least width has a fraction of a ns
	localparam int SHUTTER_US = 1;
	localparam int SHUTTER_DELAY_US = 1;
	localparam int DUMP_DELAY_NS = 75;
	// Round a least time up to whole cycles, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int HD_CYC = ns_to_cyc(HORIZ_DELAY_NS);
	localparam int VS_CYC = ns_to_cyc(VERT_STEP_NS);
	localparam int PD_CYC = ns_to_cyc(PD_XFER_NS);
	localparam int PED_CYC = ns_to_cyc(PEDESTAL_US * 1000);
	localparam int VD_CYC = ns_to_cyc(VERT_DELAY_US * 1000);
	localparam int FD_CYC = ns_to_cyc(FRAME_DELAY_US * 1000);
	localparam int LE_CYC = ns_to_cyc(LINE_END_NS);
	localparam int HP_CYC = ns_to_cyc(HORIZ_PERIOD_NS);
	localparam int SH_CYC = ns_to_cyc(SHUTTER_US * 1000);
	localparam int SD_CYC = ns_to_cyc(SHUTTER_DELAY_US * 1000);
	localparam int DD_CYC = ns_to_cyc(DUMP_DELAY_NS);
	// Geometry
	localparam logic [9:0] SINGLE_LEN = 10'h2_C4;
	localparam logic [9:0] DUAL_LEN = 10'h1_68;
	localparam logic [9:0] CENTER_COL_LEN = 10'h0_A4;
	localparam logic [9:0] FULL_ROWS = 10'h1_E0;
	localparam logic [9:0] CENTER_ROWS = 10'h0_A4;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {CCDTS_FULL, CCDTS_CCOLS, CCDTS_CROWS, CCDTS_CBOTH} ccdts_window_t;
	typedef struct packed {
		logic          dual;
		ccdts_window_t window;
	} ccdts_mode_t;
	typedef struct packed {
		logic vert_phase_one;
		logic vert_phase_two;
		logic center_vert_phase_one;
		logic center_vert_phase_two;
		logic horiz_main_phase_a;
		logic horiz_main_phase_b;
		logic horiz_left_end_phase_a;
		logic horiz_left_end_phase_b;
		logic horiz_right_end_phase_a;
		logic horiz_right_end_phase_b;
		logic left_output_reset_gate;
		logic right_output_reset_gate;
		logic line_dump_gate;
		logic center_line_dump_gate;
		logic shutter_pulse_level;
	} ccdts_pins_t;
endpackage
`default_nettype wire

// file: rtl/ccdts_sequencer.sv
// Timing generator driving an interline CCD: frame transfer, line shift, line readout.
// Assumes the clock drivers translate logic levels; all pins are one-way outputs.
`default_nettype none
module ccdts_sequencer (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Control
	input  wire logic                 frame_start,
	input  wire logic                 shutter_req,
	input  wire logic                 line_only_req,
	input  wire logic                 dump_req,
	input  wire ccdts_pkg::ccdts_mode_t mode_in,
	// Status
	output logic                      busy,
	output logic                      frame_done,
	output logic                      pixel_valid,
	output ccdts_pkg::ccdts_mode_t    mode_active,
	// Sensor pins
	output ccdts_pkg::ccdts_pins_t    pins
);
	typedef enum logic [3:0] {
		S_IDLE, S_SHUT_DLY, S_SHUT, S_FDELAY, S_PED, S_PDX, S_VDLY,
		S_VSTEP1, S_VSTEP2, S_LEND, S_HDLY, S_HCLK, S_DUMP
	} ccdts_state_t;

	ccdts_state_t                 state_reg, state_next;
	logic [ccdts_pkg::CNT_W-1:0]  tmr_reg, tmr_next;
	logic [9:0]                   pix_reg, pix_next;
	logic [9:0]                   row_reg, row_next;
	logic                         hph_reg, hph_next;
	logic                         frame_reg, frame_next;
	logic                         rgate_reg, rgate_next;
	ccdts_pkg::ccdts_mode_t       mode_reg, mode_next;
	ccdts_pkg::ccdts_pins_t       pins_reg, pins_next;
	logic                         done_reg, done_next;

	function automatic logic [ccdts_pkg::CNT_W-1:0] cyc(input int n);
		return ccdts_pkg::CNT_W'(n - 1);
	endfunction

	// Window decode kept in one place so rows and columns cannot disagree
	function automatic logic has_center_rows(input ccdts_pkg::ccdts_window_t w);
		return (w == ccdts_pkg::CCDTS_CROWS) || (w == ccdts_pkg::CCDTS_CBOTH);
	endfunction

	function automatic logic has_center_cols(input ccdts_pkg::ccdts_window_t w);
		return (w == ccdts_pkg::CCDTS_CCOLS) || (w == ccdts_pkg::CCDTS_CBOTH);
	endfunction

	function automatic logic [9:0] step10(input logic [9:0] v);
		return v + 10'h0_001;
	endfunction

	function automatic logic at_end(input logic [9:0] idx, input logic [9:0] total);
		return idx == (total - 10'h0_001);
	endfunction

	wire logic       tmr_zero   = (tmr_reg == '0);
	wire logic       center_row = has_center_rows(mode_reg.window);
	wire logic       center_col = has_center_cols(mode_reg.window);
	// Pixels per line: central window, else full register; dual shortens the full line to DUAL_LEN
	wire logic [9:0] line_len   = center_col ? ccdts_pkg::CENTER_COL_LEN :
	                              (mode_reg.dual ? ccdts_pkg::DUAL_LEN : ccdts_pkg::SINGLE_LEN);
	wire logic [9:0] row_total  = center_row ? ccdts_pkg::CENTER_ROWS : ccdts_pkg::FULL_ROWS;
	wire logic       last_pix   = at_end(pix_reg, line_len);
	wire logic       last_row   = at_end(row_reg, row_total);

	always_comb begin
		state_next = state_reg;
		tmr_next   = tmr_zero ? tmr_reg : tmr_reg - 1'b1;
		pix_next   = pix_reg;
		row_next   = row_reg;
		hph_next   = hph_reg;
		frame_next = frame_reg;
		rgate_next = 1'b0;
		mode_next  = mode_reg;
		done_next  = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (shutter_req) begin
					state_next = S_SHUT_DLY;
					tmr_next   = cyc(ccdts_pkg::SD_CYC);
				end else if (frame_start) begin
					mode_next  = mode_in;
					frame_next = 1'b1;
					row_next   = '0;
					state_next = S_FDELAY;
					tmr_next   = cyc(ccdts_pkg::FD_CYC);
				end else if (line_only_req) begin
					frame_next = 1'b0;
					pix_next   = '0;
					state_next = S_HDLY;
					tmr_next   = cyc(ccdts_pkg::HD_CYC);
				end else if (dump_req) begin
					state_next = S_DUMP;
					tmr_next   = cyc(ccdts_pkg::DD_CYC);
				end
			end
			S_SHUT_DLY: begin
				if (tmr_zero) begin
					state_next = S_SHUT;
					tmr_next   = cyc(ccdts_pkg::SH_CYC);
				end
			end
			S_SHUT: begin
				if (tmr_zero) begin
					state_next = S_IDLE;
				end
			end
			S_FDELAY: begin
				if (tmr_zero) begin
					state_next = S_PED;
					tmr_next   = cyc(ccdts_pkg::PED_CYC);
				end
			end
			S_PED: begin
				if (tmr_zero) begin
					state_next = S_PDX;
					tmr_next   = cyc(ccdts_pkg::PD_CYC);
				end
			end
			S_PDX: begin
				if (tmr_zero) begin
					state_next = S_VDLY;
					tmr_next   = cyc(ccdts_pkg::VD_CYC);
				end
			end
			S_VDLY: begin
				if (tmr_zero) begin
					state_next = S_VSTEP1;
					tmr_next   = cyc(ccdts_pkg::VS_CYC);
				end
			end
			S_VSTEP1: begin
				if (tmr_zero) begin
					state_next = S_VSTEP2;
					tmr_next   = cyc(ccdts_pkg::VS_CYC);
				end
			end
			S_VSTEP2: begin
				if (tmr_zero) begin
					state_next = S_LEND;
					tmr_next   = cyc(ccdts_pkg::LE_CYC);
				end
			end
			S_LEND: begin
				if (tmr_zero) begin
					pix_next   = '0;
					state_next = S_HDLY;
					tmr_next   = cyc(ccdts_pkg::HD_CYC);
				end
			end
			S_HDLY: begin
				if (tmr_zero) begin
					hph_next   = 1'b0;
					state_next = S_HCLK;
					tmr_next   = cyc(ccdts_pkg::HP_CYC);
				end
			end
			S_HCLK: begin
				if (tmr_zero) begin
					// One clock high, one low: each half a full cycle
					hph_next = ~hph_reg;
					tmr_next = cyc(ccdts_pkg::HP_CYC);
					if (hph_reg) begin
						rgate_next = 1'b1;
						pix_next   = step10(pix_reg);
						if (last_pix) begin
							if (frame_reg && !last_row) begin
								row_next   = step10(row_reg);
								state_next = S_VSTEP1;
								tmr_next   = cyc(ccdts_pkg::VS_CYC);
							end else begin
								done_next  = frame_reg;
								frame_next = 1'b0;
								state_next = S_IDLE;
							end
						end
					end
				end
			end
			S_DUMP: begin
				if (tmr_zero) begin
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	// Vertical phases: step 1 raises both phases, step 2 lowers phase one; each
	// step overlaps its neighbour by a full step, well over half
	wire logic in_pdx    = (state_reg == S_PDX);
	wire logic in_step1  = (state_reg == S_VSTEP1);
	wire logic in_step2  = (state_reg == S_VSTEP2);
	wire logic in_hclk   = (state_reg == S_HCLK);
	wire logic in_dump   = (state_reg == S_DUMP);
	wire logic in_shut   = (state_reg == S_SHUT);
	wire logic v1        = in_pdx || in_step1;
	wire logic v2        = in_pdx || in_step1 || in_step2;
	wire logic h1        = in_hclk && !hph_reg;
	wire logic h2        = in_hclk && hph_reg;
	// In center-row windows the center rows take the transfer alone; outer rows stay off in the transfer
	wire logic pdx_outer = in_pdx && center_row;

	always_comb begin
		pins_next = '0;
		pins_next.vert_phase_one          = v1 && !pdx_outer;
		pins_next.vert_phase_two          = v2 && !pdx_outer;
		pins_next.center_vert_phase_one   = v1;
		pins_next.center_vert_phase_two   = v2;
		pins_next.horiz_main_phase_a      = h1;
		pins_next.horiz_main_phase_b      = h2;
		pins_next.horiz_left_end_phase_a  = h1;
		pins_next.horiz_left_end_phase_b  = h2;
		pins_next.horiz_right_end_phase_a = mode_reg.dual ? h1 : h2;
		pins_next.horiz_right_end_phase_b = mode_reg.dual ? h2 : h1;
		pins_next.left_output_reset_gate  = rgate_next;
		pins_next.right_output_reset_gate = rgate_next && mode_reg.dual;
		pins_next.line_dump_gate          = in_dump;
		pins_next.center_line_dump_gate   = in_dump;
		pins_next.shutter_pulse_level     = in_shut;
	end

	// Every interval counted in system cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			tmr_reg   <= '0;
		end else begin
			state_reg <= state_next;
			tmr_reg   <= tmr_next;
		end
	end

	// Line and row position, horizontal phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pix_reg <= '0;
			row_reg <= '0;
			hph_reg <= 1'b0;
		end else begin
			pix_reg <= pix_next;
			row_reg <= row_next;
			hph_reg <= hph_next;
		end
	end

	// Mode moves only through the idle branch, so a frame keeps its geometry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_reg <= 1'b0;
			mode_reg  <= '0;
		end else begin
			frame_reg <= frame_next;
			mode_reg  <= mode_next;
		end
	end

	// Pins registered so that no decode glitch reaches the clock drivers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins_reg  <= '0;
			rgate_reg <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			pins_reg  <= pins_next;
			rgate_reg <= rgate_next;
			done_reg  <= done_next;
		end
	end

	assign pins        = pins_reg;
	assign busy        = (state_reg != S_IDLE);
	assign frame_done  = done_reg;
	assign pixel_valid = rgate_reg;
	assign mode_active = mode_reg;
endmodule
`default_nettype wire

// file: dv/ccdts_sequencer_props.sv
// Checker for the CCD timing sequencer: pin timing and mode relations.
// Assumes one clock domain; sees only the top module's ports.
`default_nettype none
module ccdts_sequencer_props (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// Status
	input wire logic                   busy,
	input wire logic                   frame_done,
	input wire logic                   pixel_valid,
	input wire ccdts_pkg::ccdts_mode_t mode_active,
	// Sensor pins
	input wire ccdts_pkg::ccdts_pins_t pins
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] sh_len_reg;
	// Counts the current shutter pulse; cleared while the pulse is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) sh_len_reg <= 8'h00;
		else sh_len_reg <= pins.shutter_pulse_level ? sh_len_reg + 8'h01 : 8'h00;
	end
	wire logic [1:0] main_ab   = {pins.horiz_main_phase_a, pins.horiz_main_phase_b};
	wire logic [1:0] right_ab  = {pins.horiz_right_end_phase_a, pins.horiz_right_end_phase_b};
	wire logic       center_eq = (pins.center_vert_phase_one == pins.vert_phase_one)
		&& (pins.center_vert_phase_two == pins.vert_phase_two);
	sequence s_pixel;
		pins.horiz_main_phase_a ##1 (pins.horiz_main_phase_b && !pins.horiz_main_phase_a);
	endsequence
	sequence s_dump;
		(pins.line_dump_gate && pins.center_line_dump_gate)[*2] ##1 !pins.line_dump_gate;
	endsequence
	a_shutter_width: assert property ($fell(pins.shutter_pulse_level) |-> sh_len_reg == 8'(ccdts_pkg::SH_CYC))
		else $error("shutter pulse width wrong");
	a_shutter_delay: assert property ($rose(pins.shutter_pulse_level) |-> $past(busy, 20))
		else $error("shutter pulse came too early");
	a_phase_overlap: assert property (pins.vert_phase_one |-> pins.vert_phase_two)
		else $error("vertical phases do not overlap");
	a_vert_step_min: assert property ($rose(pins.vert_phase_one) |-> pins.vert_phase_one[*4])
		else $error("vertical step too short");
	a_horiz_pixel_seq: assert property ($rose(pins.horiz_main_phase_a) |-> s_pixel)
		else $error("horizontal phase order wrong");
	a_pixel_reset_gate: assert property (pixel_valid |-> pins.left_output_reset_gate
		&& pins.horiz_main_phase_b && $past(pins.horiz_main_phase_a))
		else $error("reset gate not with pixel");
	a_right_end_map: assert property (right_ab == (mode_active.dual ? main_ab : {main_ab[0], main_ab[1]}))
		else $error("right end phases wrong");
	a_right_gate_dual: assert property (pins.right_output_reset_gate |-> mode_active.dual)
		else $error("right reset gate in single mode");
	a_center_follow: assert property (!mode_active.window[1] |-> center_eq)
		else $error("center phases differ from main");
	a_mode_hold: assert property (busy && $past(busy) |-> $stable(mode_active))
		else $error("mode changed inside a frame");
	a_frame_done: assert property (frame_done |-> pixel_valid && !busy)
		else $error("frame done not after last pixel");
	a_dump_pulse: assert property ($rose(pins.line_dump_gate) |-> s_dump)
		else $error("dump pulse length wrong");
endmodule
bind ccdts_sequencer ccdts_sequencer_props ccdts_sequencer_props_inst (.clk(clk), .rst(rst), .busy(busy),
	.frame_done(frame_done), .pixel_valid(pixel_valid), .mode_active(mode_active), .pins(pins));
`default_nettype wire

// file: dv/ccdts_sensor_model.sv
// Sensor model: counts pixels leaving each output since the last line shift.
// Assumes pins are sampled on the generator's clock.
`default_nettype none
module ccdts_sensor_model (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Sensor pins
	input  wire ccdts_pkg::ccdts_pins_t pins,
	// Pixel counts
	output logic [15:0]                 left_px,
	output logic [15:0]                 right_px
);
	wire logic line_shift = pins.vert_phase_two | pins.center_vert_phase_two;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_px <= 16'h0000;
			right_px <= 16'h0000;
		end else if (line_shift) begin
			left_px <= 16'h0000;
			right_px <= 16'h0000;
		end else begin
			left_px <= left_px + 16'(pins.left_output_reset_gate);
			right_px <= right_px + 16'(pins.right_output_reset_gate);
		end
	end
endmodule
`default_nettype wire

// file: dv/tb_ccdts_sequencer.sv
// Testbench for the CCD timing sequencer: line, shutter, dump and center frame.
// Assumes a 20 MHz clock; full frames are too long, so the frame uses center rows.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_ccdts_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   frame_start = 1'b0;
	logic                   shutter_req = 1'b0;
	logic                   line_only_req = 1'b0;
	logic                   dump_req = 1'b0;
	ccdts_pkg::ccdts_mode_t mode_in = '0;
	logic                   busy, frame_done, pixel_valid;
	ccdts_pkg::ccdts_mode_t mode_active;
	ccdts_pkg::ccdts_pins_t pins;
	logic [15:0]            left_px, right_px;
	int                     n_errors = 0;
	int                     n_checks = 0;
	int                     seed = 32'h0000_5b6e;
	int                     npix, nsh, ndump, nfd;
	always #25 clk = ~clk;
	ccdts_sequencer ccdts_sequencer_inst (.clk(clk), .rst(rst), .frame_start(frame_start), .shutter_req(shutter_req),
		.line_only_req(line_only_req), .dump_req(dump_req), .mode_in(mode_in), .busy(busy),
		.frame_done(frame_done), .pixel_valid(pixel_valid), .mode_active(mode_active), .pins(pins));
	ccdts_sensor_model ccdts_sensor_model_inst (.clk(clk), .rst(rst), .pins(pins), .left_px(left_px),
		.right_px(right_px));
	always @(posedge clk) begin
		npix += int'(pixel_valid === 1'b1);
		nsh += int'(pins.shutter_pulse_level === 1'b1);
		ndump += int'(pins.line_dump_gate === 1'b1);
		nfd += int'(frame_done === 1'b1);
	end
	// Pixels per line from the latched mode
	function automatic int exp_px(input logic [2:0] m);
		if (m[1:0] == 2'h1 || m[1:0] == 2'h3) return 164;
		return m[2] ? 360 : 708;
	endfunction
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Which: 0 shutter, 1 frame, 2 line only, 3 dump; mode_in churns while a frame runs
	task automatic go(input int which, input int limit);
		int k;
		@(negedge clk);
		npix = 0; nsh = 0; ndump = 0; nfd = 0;
		case (which)
			0: shutter_req = 1'b1;
			1: frame_start = 1'b1;
			2: line_only_req = 1'b1;
			default: dump_req = 1'b1;
		endcase
		@(negedge clk);
		{shutter_req, frame_start, line_only_req, dump_req} = 4'h0;
		k = 0;
		while (busy !== 1'b0 && k < limit) begin
			@(negedge clk);
			if (which == 1) mode_in = 3'($random(seed));
			k++;
		end
		// Last pin pulses follow the return to idle by one cycle
		repeat (2) @(negedge clk);
		`CHK("busy_clear", 1'b0, busy)
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		mode_in = 3'($random(seed));
		go(2, 5000);
		`CHK("mode_held", 3'h0, mode_active)
		`CHK("line_px", exp_px(3'h0), npix)
		`CHK("left_px", 16'(exp_px(3'h0)), left_px)
		`CHK("right_px", 16'h0000, right_px)
		go(0, 200);
		`CHK("shutter_len", 20, nsh)
		go(3, 50);
		`CHK("dump_len", 2, ndump)
		// Random mode latched by a frame, then reset cuts the frame short
		mode_in = 3'($random(seed));
		frame_start = 1'b1;
		@(negedge clk);
		frame_start = 1'b0;
		repeat (4) @(negedge clk);
		`CHK("mode_rand", mode_in, mode_active)
		`CHK("frame_busy", 1'b1, busy)
		rst = 1'b1;
		@(negedge clk);
		`CHK("rst_mode", 3'h0, mode_active)
		`CHK("rst_pins", 15'h0000, pins)
		rst = 1'b0;
		mode_in = 3'h7;
		go(1, 70000);
		`CHK("mode_latched", 3'h7, mode_active)
		`CHK("frame_px", 164 * exp_px(3'h7), npix)
		`CHK("frame_done", 1, nfd)
		`CHK("frame_left", 16'(exp_px(3'h7)), left_px)
		`CHK("frame_right", 16'(exp_px(3'h7)), right_px)
		final_report;
	end
	// Whole run needs about 60000 cycles; this margin cuts a hang short
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		final_report;
	end
endmodule
`default_nettype wire
